/* rtl/conv_ctrl0.sv */
`timescale 1ns/1ps
// What this block does
// - enable, soft reset, freeze and wait halt bits are writable at any time.
// - flow mode, abort store, access config writable only if disabled or special access.
// - bit 15 enables; clearing it aborts the sequence and discards results.
// - re-enable is refused until the disable latency has run out.
// - no conversion starts before the enable recovery time has passed.
// - soft reset clears overrun and error flags and forces the sequencer idle.
// - soft reset zeroes command and result indexes and both list selects.
// - a severe error stops conversion until a soft reset is done.
// - soft reset bit ignores writes once set and self-clears when done.
// - freeze halt select set stops at next conversion boundary in freeze mode.
// - wait halt select set halts at next conversion boundary in wait mode.
module conv_ctrl0
  import conv_ctrl_pkg::*;
#(
  parameter int IDX_W = 6
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // register port
  input wire conv_ctrl_pkg::reg_req_t req_i,
  output logic [15:0] rdata_o,
  // system events
  input wire conv_ctrl_pkg::sys_evt_t evt_i,
  input wire logic special_mode_access_i,
  // converter status
  output logic converting_o,
  output logic result_store_o,
  output logic [IDX_W-1:0] cmd_idx_o,
  output logic [IDX_W-1:0] res_idx_o
);
  import conv_ctrl_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CONV = 4'h2,
    ST_HALT = 4'h4,
    ST_ERR = 4'h8
  } seq_state_t;

  seq_state_t state_q, state_d;
  logic [15:0] ctrl_q, ctrl_d;
  logic [15:0] rdata_q;
  logic [IDX_W-1:0] cmd_idx_q, res_idx_q;
  logic [3:0] conv_cnt_q;
  logic cmd_sel_q, res_sel_q;
  logic overrun_q, error_q;
  logic result_q, conv_q;
  logic [1:0] sr_cnt_q;
  logic rec_busy_q;

  // register decode
  wire ctrl_wr = req_i.wr && (req_i.addr == CTRL0_OFS);
  wire enabled = ctrl_q[EN_BIT];
  wire sr_active = ctrl_q[SR_BIT];
  wire cfg_open = !enabled || special_mode_access_i;
  wire dis_busy;
  wire rec_busy;
  wire en_req = ctrl_wr && req_i.wdata[EN_BIT];
  wire en_rise = en_req && !enabled && !dis_busy;
  wire en_fall = ctrl_wr && !req_i.wdata[EN_BIT] && enabled;
  wire sr_done = sr_active && (sr_cnt_q == 2'(SR_CYC - 1));
  wire halt_req = (evt_i.frz_mode && ctrl_q[FRZ_BIT])
    || (evt_i.wait_mode && ctrl_q[WAI_BIT]);
  wire boundary = (state_q == ST_CONV) && (conv_cnt_q == 4'(CONV_CYC - 1));
  wire can_start = enabled && !rec_busy && !sr_active;

  conv_cycle_timer #(.WIDTH(8)) dis_timer (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .load_i(en_fall),
    .value_i(8'(DISABLE_CYC)),
    .busy_o(dis_busy)
  );

  conv_cycle_timer #(.WIDTH(8)) rec_timer (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .load_i(en_rise),
    .value_i(8'(REC_CYC)),
    .busy_o(rec_busy)
  );

  // control register next value
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (ctrl_wr)
    begin
      ctrl_d[FRZ_BIT] = req_i.wdata[FRZ_BIT];
      ctrl_d[WAI_BIT] = req_i.wdata[WAI_BIT];
      if (!req_i.wdata[EN_BIT])
        ctrl_d[EN_BIT] = 1'b0;
      else if (en_rise)
        ctrl_d[EN_BIT] = 1'b1;
      if (req_i.wdata[SR_BIT])
        ctrl_d[SR_BIT] = 1'b1;
      if (cfg_open)
      begin
        ctrl_d[ACC_HI_BIT:ACC_LO_BIT] = req_i.wdata[ACC_HI_BIT:ACC_LO_BIT];
        ctrl_d[STR_BIT] = req_i.wdata[STR_BIT];
        ctrl_d[MOD_BIT] = req_i.wdata[MOD_BIT];
      end
    end
    if (sr_done)
      ctrl_d[SR_BIT] = 1'b0;
    ctrl_d[7:0] = 8'h00;
  end

  // sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (can_start && evt_i.trigger)
          state_d = ST_CONV;
      ST_CONV:
        if (boundary && halt_req)
          state_d = ST_HALT;
      ST_HALT:
        if (!halt_req)
          state_d = ST_CONV;
      ST_ERR:
        state_d = ST_ERR;
      default:
        state_d = ST_IDLE;
    endcase
    if (evt_i.severe_err && state_q != ST_IDLE)
      state_d = ST_ERR;
    if (!enabled)
      state_d = (state_q == ST_ERR) ? ST_ERR : ST_IDLE;
    if (sr_active)
      state_d = ST_IDLE;
  end

  wire [15:0] status_word = {state_q, overrun_q, error_q, cmd_sel_q, res_sel_q,
                             rec_busy_q, dis_busy, 6'h00};
  wire [15:0] index_word = {2'h0, cmd_idx_q, 2'h0, res_idx_q};
  wire [15:0] rd_mux = (req_i.addr == CTRL0_OFS) ? ctrl_q :
                       (req_i.addr == STATUS_OFS) ? status_word :
                       (req_i.addr == INDEX_OFS) ? index_word : 16'h0000;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      ctrl_q <= CTRL0_RESET;
      state_q <= ST_IDLE;
      rdata_q <= 16'h0000;
      sr_cnt_q <= 2'h0;
      rec_busy_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      state_q <= state_d;
      rdata_q <= req_i.rd ? rd_mux : 16'h0000;
      sr_cnt_q <= sr_active ? sr_cnt_q + 2'h1 : 2'h0;
      rec_busy_q <= rec_busy;
    end
  end

  // conversion progress, indexes and flags
  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      conv_cnt_q <= 4'h0;
      cmd_idx_q <= '0;
      res_idx_q <= '0;
      cmd_sel_q <= 1'b0;
      res_sel_q <= 1'b0;
      overrun_q <= 1'b0;
      error_q <= 1'b0;
      result_q <= 1'b0;
      conv_q <= 1'b0;
    end
    else
    begin
      conv_q <= (state_d == ST_CONV);
      // a disable write in the boundary cycle still throws the result away
      result_q <= boundary && !en_fall && (state_d != ST_IDLE)
        && (state_d != ST_ERR);
      if (state_q == ST_CONV && state_d == ST_CONV)
        conv_cnt_q <= boundary ? 4'h0 : conv_cnt_q + 4'h1;
      else if (state_q != ST_HALT)
        conv_cnt_q <= 4'h0;
      if (boundary && state_d != ST_IDLE && state_d != ST_ERR)
      begin
        cmd_idx_q <= cmd_idx_q + 1'b1;
        res_idx_q <= res_idx_q + 1'b1;
        overrun_q <= overrun_q | (&res_idx_q);
      end
      if (evt_i.severe_err && state_q != ST_IDLE)
        error_q <= 1'b1;
      if (sr_active)
      begin
        overrun_q <= 1'b0;
        error_q <= 1'b0;
        cmd_idx_q <= '0;
        res_idx_q <= '0;
        cmd_sel_q <= 1'b0;
        res_sel_q <= 1'b0;
      end
    end
  end

  assign rdata_o = rdata_q;
  assign converting_o = conv_q;
  assign result_store_o = result_q;
  assign cmd_idx_o = cmd_idx_q;
  assign res_idx_o = res_idx_q;

  // cycles left in which the sequencer must stay idle after an accepted enable;
  // a counter is used because the window is far too long to unroll in a property
  logic [7:0] rec_chk_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      rec_chk_q <= 8'h00;
    else if (en_rise)
      rec_chk_q <= 8'(REC_CYC);
    else if (rec_chk_q != 8'h00)
      rec_chk_q <= rec_chk_q - 8'h01;
  end

  sequence sr_write_s;
    ctrl_wr && req_i.wdata[SR_BIT];
  endsequence

  sequence locked_en_write_s;
    ctrl_wr && req_i.wdata[EN_BIT] && !enabled && dis_busy;
  endsequence

  sequence halted_s;
    state_q == ST_HALT && !sr_active && !evt_i.severe_err;
  endsequence

  sequence wait_boundary_s;
    boundary && evt_i.wait_mode && ctrl_q[WAI_BIT] && enabled;
  endsequence

  sequence sr_clear_try_s;
    sr_active && !sr_done && ctrl_wr && !req_i.wdata[SR_BIT];
  endsequence

  sr_self_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sr_write_s ##1 ctrl_q[SR_BIT] |-> ##[1:2] !ctrl_q[SR_BIT])
    else $error("soft reset bit did not self-clear");
  sr_sticky_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sr_active && !sr_done |=> ctrl_q[SR_BIT])
    else $error("soft reset bit cleared early");
  sr_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sr_active |=> state_q == ST_IDLE && !error_q && !overrun_q)
    else $error("soft reset left flags or state");
  sr_index_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sr_active |=> cmd_idx_q == '0 && res_idx_q == '0 && !cmd_sel_q && !res_sel_q)
    else $error("soft reset left indexes");
  cfg_lock_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctrl_wr && enabled && !special_mode_access_i |=> $stable(ctrl_q[11:8]))
    else $error("locked config bits changed");
  any_time_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctrl_wr |=> ctrl_q[FRZ_BIT] == $past(req_i.wdata[FRZ_BIT])
      && ctrl_q[WAI_BIT] == $past(req_i.wdata[WAI_BIT]))
    else $error("halt select write lost");
  disable_abort_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    en_fall |=> !result_q ##1 !converting_o)
    else $error("disable did not abort");
  reenable_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    en_fall ##1 en_req |=> !enabled)
    else $error("re-enable accepted too early");
  recovery_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    rec_chk_q != 8'h00 |-> state_q == ST_IDLE)
    else $error("conversion before recovery");
  recovery_load_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    en_rise |=> rec_chk_q != 8'h00 && !converting_o)
    else $error("recovery window not started");
  reenable_window_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    locked_en_write_s |=> !ctrl_q[EN_BIT])
    else $error("enable taken inside disable latency");
  sr_ignore_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    sr_clear_try_s |=> ctrl_q[SR_BIT])
    else $error("soft reset bit cleared by software");
  cfg_open_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctrl_wr && cfg_open |=> ctrl_q[11:8] == $past(req_i.wdata[11:8]))
    else $error("open config write lost");
  en_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    ctrl_wr && !req_i.wdata[EN_BIT] |=> !ctrl_q[EN_BIT])
    else $error("enable clear write lost");
  wait_halt_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    wait_boundary_s && !sr_active && !evt_i.severe_err |=> state_q == ST_HALT)
    else $error("no wait halt at boundary");
  resume_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    halted_s and (enabled && !halt_req) |=> state_q == ST_CONV)
    else $error("halted sequence did not resume");
  idx_hold_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    halted_s |=> $stable(cmd_idx_q))
    else $error("command index moved while halted");
  err_quiet_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ST_ERR |=> !converting_o && !result_store_o)
    else $error("conversion while in error state");
  off_no_store_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !enabled |=> !result_store_o)
    else $error("result stored while disabled");
  rd_idle_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    !req_i.rd |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");
  halt_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    boundary && halt_req && enabled && !sr_active && !evt_i.severe_err |=> state_q == ST_HALT)
    else $error("no halt at boundary");
  severe_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
    state_q == ST_ERR && !sr_active |=> state_q == ST_ERR)
    else $error("left error state without soft reset");
endmodule

/* rtl/conv_ctrl_pkg.sv */
package conv_ctrl_pkg;

  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] INDEX_OFS = 8'h08;

  localparam int EN_BIT = 15;
  localparam int SR_BIT = 14;
  localparam int FRZ_BIT = 13;
  localparam int WAI_BIT = 12;
  localparam int ACC_HI_BIT = 11;
  localparam int ACC_LO_BIT = 10;
  localparam int STR_BIT = 9;
  localparam int MOD_BIT = 8;

  localparam logic [15:0] CTRL0_RESET = 16'h0000;

  localparam int CLK_MHZ = 250;
  localparam int DISABLE_TIME_NS = 100;
  localparam int REC_TIME_NS = 200;
  localparam int DISABLE_CYC = (DISABLE_TIME_NS * CLK_MHZ) / 1000;
  localparam int REC_CYC = (REC_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int SR_CYC = 2;
  localparam int CONV_CYC = 8;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic frz_mode;
    logic wait_mode;
    logic trigger;
    logic severe_err;
  } sys_evt_t;

endpackage

/* rtl/conv_cycle_timer.sv */
`timescale 1ns/1ps
// down-counter used for latency windows; busy while count is non-zero
module conv_cycle_timer #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic srst_i,
  // control
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic busy_o
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  assign cnt_d = load_i ? value_i : (cnt_q != '0 ? cnt_q - 1'b1 : cnt_q);
  assign busy_o = (cnt_q != '0);

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule

/* bench/conv_ctrl0_tb_top.sv */
`timescale 1ns/1ps
module conv_ctrl0_tb_top;
  import conv_ctrl_pkg::*;
  logic clk_sys_i;
  logic srst_i;
  reg_req_t req;
  sys_evt_t evt;
  logic sma;
  logic [15:0] rdata;
  logic conv;
  logic store;
  logic [5:0] cidx;
  logic [5:0] ridx;
  logic [5:0] held;
  logic [15:0] v;
  int fails;
  int cmp_count;
  int n;

  conv_ctrl0 #(.IDX_W(6)) DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_i(req),
    .rdata_o(rdata), .evt_i(evt), .special_mode_access_i(sma), .converting_o(conv),
    .result_store_o(store), .cmd_idx_o(cidx), .res_idx_o(ridx));

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk_sys_i);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk_sys_i);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // which 0 watches converting, 1 watches result store
  task automatic wait_sig(input int which, input logic lvl, input int bound, output int cnt);
    cnt = 0;
    while ((which == 1 ? store : conv) !== lvl)
    begin
      @(posedge clk_sys_i);
      #1;
      cnt++;
      if (cnt > bound)
      begin
        fails++;
        $display("wrong value at %0t: status output never reached level", $time);
        give_verdict();
      end
    end
  endtask

  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    fails = 0;
    cmp_count = 0;
    srst_i = 1'b1;
    req = '0;
    evt = '0;
    sma = 1'b0;
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    rd(CTRL0_OFS, v);
    chk_val(v, CTRL0_RESET);
    rd(8'h20, v);
    chk_val(v, 16'h0000);
    wr(CTRL0_OFS, 16'h0300);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'h0300);
    evt.trigger <= 1'b1;
    wr(CTRL0_OFS, 16'h8300);
    wait_sig(0, 1'b1, REC_CYC + 4, n);
    chk_flag(n >= REC_CYC - 1, 1'b1);
    wr(CTRL0_OFS, 16'hB000);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'hB300);
    sma <= 1'b1;
    wr(CTRL0_OFS, 16'h8C00);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'h8C00);
    sma <= 1'b0;
    for (int m = 0; m < 2; m++)
    begin
      wr(CTRL0_OFS, (m == 1) ? 16'h9000 : 16'hA000);
      wait_sig(0, 1'b1, CONV_CYC + 4, n);
      evt.frz_mode <= (m == 0);
      evt.wait_mode <= (m == 1);
      wait_sig(0, 1'b0, CONV_CYC + 4, n);
      held = cidx;
      repeat (2 * CONV_CYC) @(posedge clk_sys_i);
      #1;
      chk_flag(conv, 1'b0);
      chk_val({10'h000, cidx}, {10'h000, held});
      evt.frz_mode <= 1'b0;
      evt.wait_mode <= 1'b0;
      wait_sig(1, 1'b1, 2 * CONV_CYC + 4, n);
      chk_flag((cidx - held) <= 6'h01, 1'b1);
    end
    wait_sig(0, 1'b1, CONV_CYC + 4, n);
    wr(CTRL0_OFS, 16'h0000);
    wait_sig(0, 1'b0, 2, n);
    for (int i = 0; i < CONV_CYC + 2; i++)
    begin
      @(posedge clk_sys_i);
      #1;
      chk_flag(store, 1'b0);
    end
    // still inside the disable latency, so this enable is refused
    wr(CTRL0_OFS, 16'h8C00);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'h0C00);
    repeat (DISABLE_CYC) @(posedge clk_sys_i);
    wr(CTRL0_OFS, 16'h8C00);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'h8C00);
    wait_sig(1, 1'b1, REC_CYC + 2 * CONV_CYC, n);
    evt.severe_err <= 1'b1;
    @(posedge clk_sys_i);
    evt.severe_err <= 1'b0;
    evt.trigger <= 1'b0;
    wait_sig(0, 1'b0, CONV_CYC + 4, n);
    evt.trigger <= 1'b1;
    repeat (2 * CONV_CYC) @(posedge clk_sys_i);
    #1;
    chk_flag(conv, 1'b0);
    evt.trigger <= 1'b0;
    wr(CTRL0_OFS, 16'hCC00);
    repeat (SR_CYC + 2) @(posedge clk_sys_i);
    #1;
    chk_val({cidx, 4'h0, ridx}, 16'h0000);
    rd(STATUS_OFS, v);
    chk_val(v & 16'h0F00, 16'h0000);
    rd(CTRL0_OFS, v);
    chk_val(v, 16'h8C00);
    evt.trigger <= 1'b1;
    wait_sig(0, 1'b1, REC_CYC + CONV_CYC, n);
    give_verdict();
  end
endmodule
